// [pdc_defines.vh]
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// Register page and offsets
`define PDC_PAGE_USER 8'h02
`define PDC_UPPER_BASE 8'h80
`define PDC_ADDR_PMODE 8'h5D
`define PDC_ADDR_PWR 8'h62
`define PDC_ADDR_CNT_LO 8'h8D
`define PDC_ADDR_CNT_HI 8'h8E
`define PDC_ADDR_DLY_HI 8'h8F
`define PDC_ADDR_DLY_LO 8'h90
`define PDC_ADDR_RST_PIN 8'h91
`define PDC_ADDR_LP_PIN 8'h92
`define PDC_ADDR_INT_PIN 8'h93

// Field positions
`define PDC_DUTY_MSB 5
`define PDC_BIT_SPOT_A 6
`define PDC_BIT_SPOT_B 7
`define PDC_BIT_OVR 0
`define PDC_BIT_SEL 1

// Reset and fixed values
`define PDC_RD_IN_RESET 8'hFF
`define PDC_DLY_RST 8'h00
`define PDC_INT_RST 1'b1
`define PDC_ZERO8 8'h00

// Temperature, signed 1/256 degC
`define PDC_CUTOFF 16'h4600
`define PDC_HYST 16'h0500

// Timing
`define PDC_CLK_NS 8
`define PDC_DELAY_UNIT_NS 1000
`define PDC_US_CYCLES (`PDC_DELAY_UNIT_NS / `PDC_CLK_NS)

// Staging, power in half milliwatts
`define PDC_STAGE_LAST 5'h14
`define PDC_STAGE_HMW 15'h0333
`define PDC_SPOT_HMW 15'h1900
`define PDC_PWM_HMW 22'h000DFC
`define PDC_PWM_TOP 6'h3E

`endif

// [pdc_pwm.v]
`timescale 1ns/1ps
`include "pdc_defines.vh"

module pdc_pwm (
  clk_sys,
  rst_n,
  duty,
  pwm_out
);
  input wire clk_sys;
  input wire rst_n;
  input wire [5:0] duty;
  output reg pwm_out;

  reg [5:0] cnt_r;

  // Period of 63 clocks so duty 63 is fully on
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_r <= 6'h00;
      pwm_out <= 1'b0;
    end
    else
    begin
      cnt_r <= (cnt_r == `PDC_PWM_TOP) ? 6'h00 : cnt_r + 6'h01;
      pwm_out <= (cnt_r < duty);
    end
  end
endmodule // pdc_pwm

// [pdc_stager.v]
`timescale 1ns/1ps
`include "pdc_defines.vh"

module pdc_stager (
  clk_sys,
  rst_n,
  restart,
  delay_us,
  stage
);
  input wire clk_sys;
  input wire rst_n;
  input wire restart;
  input wire [15:0] delay_us;
  output reg [4:0] stage;

  localparam [31:0] US_CYC = `PDC_US_CYCLES;
  localparam [6:0] US_M1 = US_CYC[6:0] - 7'h01;

  reg [6:0] us_cnt_r;
  reg [15:0] dly_cnt_r;
  wire dly_off;

  assign dly_off = (delay_us == 16'h0000);

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stage <= 5'h00;
      us_cnt_r <= 7'h00;
      dly_cnt_r <= 16'h0000;
    end
    else if (restart)
    begin
      stage <= dly_off ? `PDC_STAGE_LAST : 5'h01;
      us_cnt_r <= 7'h00;
      dly_cnt_r <= 16'h0000;
    end
    else if (dly_off)
      stage <= `PDC_STAGE_LAST;
    else if (stage < `PDC_STAGE_LAST)
    begin
      if (us_cnt_r == US_M1)
      begin
        us_cnt_r <= 7'h00;
        if (dly_cnt_r == delay_us - 16'h0001)
        begin
          dly_cnt_r <= 16'h0000;
          stage <= stage + 5'h01;
        end
        else
          dly_cnt_r <= dly_cnt_r + 16'h0001;
      end
      else
        us_cnt_r <= us_cnt_r + 7'h01;
    end
  end
endmodule // pdc_stager

// [pdc_top.v]
`timescale 1ns/1ps
`include "pdc_defines.vh"

module pdc_top (
  clk_sys,
  rst_n,
  reg_page,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  module_reset_n_pin,
  low_power_pin,
  interrupt_n_pin_o,
  interrupt_n_pin_oe,
  module_temp,
  nv_power_value,
  nv_plug_count,
  nv_power_wr,
  nv_power_data,
  nv_count_wr,
  nv_count_data,
  pwm_heater_out,
  spot_a_out,
  spot_b_out,
  low_power_mode
);
  input wire clk_sys;
  input wire rst_n;
  input wire [7:0] reg_page;
  input wire [7:0] reg_addr;
  input wire reg_wr;
  input wire reg_rd;
  input wire [7:0] reg_wdata;
  output reg [7:0] reg_rdata;
  input wire module_reset_n_pin;
  input wire low_power_pin;
  output reg interrupt_n_pin_o;
  output reg interrupt_n_pin_oe;
  input wire [15:0] module_temp;
  input wire [7:0] nv_power_value;
  input wire [15:0] nv_plug_count;
  output reg nv_power_wr;
  output reg [7:0] nv_power_data;
  output reg nv_count_wr;
  output reg [15:0] nv_count_data;
  output wire pwm_heater_out;
  output reg spot_a_out;
  output reg spot_b_out;
  output reg low_power_mode;

  localparam [2:0] ST_LOAD = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] pwr_r;
  reg [15:0] count_r;
  reg [7:0] dly_hi_r;
  reg [7:0] dly_lo_r;
  reg [15:0] dly_act_r;
  reg ovr_r;
  reg sel_r;
  reg int_lvl_r;
  reg hot_r;
  reg [5:0] pwm_lim_r;
  reg [5:0] duty_r;
  reg [7:0] rd_nxt;
  wire lp_nxt;
  wire upper;
  wire in_user;
  wire wr_ok;
  wire restart;
  wire [4:0] stage;
  wire [14:0] budget;
  wire a_fit;
  wire [14:0] used_a;
  wire b_fit;
  wire [14:0] rem;
  wire [21:0] rem_x;
  wire [21:0] lim_up_x;
  wire [21:0] lim_x;
  wire [5:0] duty_tgt;
  wire [5:0] duty_cap;
  wire active;
  wire [15:0] dly_use;

  assign upper = (reg_addr >= `PDC_UPPER_BASE);
  assign in_user = upper && (reg_page == `PDC_PAGE_USER);
  // Slave is held off while the module reset pin is low
  assign wr_ok = reg_wr && (state_r == ST_RUN) && module_reset_n_pin;
  assign lp_nxt = ovr_r ? sel_r : low_power_pin;
  assign active = (state_r == ST_RUN) && !low_power_mode;
  // Restart ramp on each initialisation and on entering high power
  assign restart = (state_r == ST_LOAD) ||
    (low_power_mode && !lp_nxt);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: state_nxt = ST_RUN;
      ST_RUN:
        if (!module_reset_n_pin)
          state_nxt = ST_HOLD;
      ST_HOLD:
        if (module_reset_n_pin)
          state_nxt = ST_LOAD;
      default: state_nxt = ST_LOAD;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= ST_LOAD;
      pwr_r <= `PDC_ZERO8;
      count_r <= 16'h0000;
      dly_hi_r <= `PDC_DLY_RST;
      dly_lo_r <= `PDC_DLY_RST;
      dly_act_r <= 16'h0000;
      ovr_r <= 1'b0;
      sel_r <= 1'b0;
      int_lvl_r <= `PDC_INT_RST;
      nv_power_wr <= 1'b0;
      nv_power_data <= `PDC_ZERO8;
      nv_count_wr <= 1'b0;
      nv_count_data <= 16'h0000;
      low_power_mode <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      low_power_mode <= lp_nxt;
      nv_power_wr <= 1'b0;
      nv_count_wr <= 1'b0;
      if (state_r == ST_LOAD)
      begin
        pwr_r <= nv_power_value;
        count_r <= nv_plug_count + 16'h0001;
        nv_count_wr <= 1'b1;
        nv_count_data <= nv_plug_count + 16'h0001;
        // Delay bytes are only sampled here, so edits wait for reset
        dly_act_r <= {dly_hi_r, dly_lo_r};
      end
      if (wr_ok && !upper && reg_addr == `PDC_ADDR_PWR)
      begin
        pwr_r <= reg_wdata;
        nv_power_wr <= 1'b1;
        nv_power_data <= reg_wdata;
      end
      if (wr_ok && !upper && reg_addr == `PDC_ADDR_PMODE)
      begin
        ovr_r <= reg_wdata[`PDC_BIT_OVR];
        sel_r <= reg_wdata[`PDC_BIT_SEL];
      end
      if (wr_ok && in_user && reg_addr == `PDC_ADDR_DLY_HI)
        dly_hi_r <= reg_wdata;
      if (wr_ok && in_user && reg_addr == `PDC_ADDR_DLY_LO)
        dly_lo_r <= reg_wdata;
      if (wr_ok && in_user && reg_addr == `PDC_ADDR_INT_PIN)
        int_lvl_r <= reg_wdata[0];
    end
  end

  always @*
  begin
    rd_nxt = `PDC_ZERO8;
    if (!upper)
    begin
      if (reg_addr == `PDC_ADDR_PWR)
        rd_nxt = pwr_r;
      else if (reg_addr == `PDC_ADDR_PMODE)
        rd_nxt = {6'h00, sel_r, ovr_r};
    end
    else if (in_user)
    begin
      case (reg_addr)
        `PDC_ADDR_CNT_LO: rd_nxt = count_r[7:0];
        `PDC_ADDR_CNT_HI: rd_nxt = count_r[15:8];
        `PDC_ADDR_DLY_HI: rd_nxt = dly_hi_r;
        `PDC_ADDR_DLY_LO: rd_nxt = dly_lo_r;
        `PDC_ADDR_RST_PIN: rd_nxt = {7'h00, module_reset_n_pin};
        `PDC_ADDR_LP_PIN: rd_nxt = {7'h00, low_power_pin};
        default: rd_nxt = `PDC_ZERO8;
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata <= `PDC_ZERO8;
    else if (reg_rd)
      reg_rdata <= (state_r == ST_RUN && module_reset_n_pin) ?
        rd_nxt : `PDC_RD_IN_RESET;
  end

  // Open collector: pull low, release for high
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      interrupt_n_pin_o <= 1'b0;
      interrupt_n_pin_oe <= 1'b0;
    end
    else
    begin
      interrupt_n_pin_o <= 1'b0;
      interrupt_n_pin_oe <= !int_lvl_r;
    end
  end

  // Signed compare with hysteresis
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      hot_r <= 1'b0;
    else if ($signed(module_temp) >= $signed(`PDC_CUTOFF))
      hot_r <= 1'b1;
    else if ($signed(module_temp) <=
      $signed(`PDC_CUTOFF - `PDC_HYST))
      hot_r <= 1'b0;
  end

  // Stager restarts in LOAD, before the latched copy settles
  assign dly_use = (state_r == ST_LOAD) ? {dly_hi_r, dly_lo_r} :
    dly_act_r;

  pdc_stager u_stager (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(restart),
    .delay_us(dly_use),
    .stage(stage)
  );

  // Budget grows 5% per stage; static spots first, PWM takes the rest
  assign budget = {10'h000, stage} * `PDC_STAGE_HMW;
  assign a_fit = pwr_r[`PDC_BIT_SPOT_A] && (budget >= `PDC_SPOT_HMW);
  assign used_a = a_fit ? `PDC_SPOT_HMW : 15'h0000;
  assign b_fit = pwr_r[`PDC_BIT_SPOT_B] &&
    ((budget - used_a) >= `PDC_SPOT_HMW);
  assign rem = budget - used_a - (b_fit ? `PDC_SPOT_HMW : 15'h0000);
  assign rem_x = {7'h00, rem} * 22'h00003F;
  assign lim_up_x = {16'h0000, pwm_lim_r + 6'h01} * `PDC_PWM_HMW;
  assign lim_x = {16'h0000, pwm_lim_r} * `PDC_PWM_HMW;
  assign duty_tgt = pwr_r[`PDC_DUTY_MSB:0];
  assign duty_cap = (duty_tgt < pwm_lim_r) ? duty_tgt : pwm_lim_r;

  // Limit tracks the budget one step per clock, far faster than a stage
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      pwm_lim_r <= 6'h00;
    else if (lim_x > rem_x)
      pwm_lim_r <= pwm_lim_r - 6'h01;
    else if (pwm_lim_r != 6'h3F && lim_up_x <= rem_x)
      pwm_lim_r <= pwm_lim_r + 6'h01;
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      duty_r <= 6'h00;
      spot_a_out <= 1'b0;
      spot_b_out <= 1'b0;
    end
    else
    begin
      // Over-temperature gates only PWM; static spots stay as set
      duty_r <= (active && !hot_r) ? duty_cap : 6'h00;
      spot_a_out <= active && a_fit;
      spot_b_out <= active && b_fit;
    end
  end

  pdc_pwm u_pwm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .duty(duty_r),
    .pwm_out(pwm_heater_out)
  );
endmodule // pdc_top

// [pdc_asserts.sv]
`timescale 1ns/1ps
module pdc_asserts (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_page,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire module_reset_n_pin,
  input wire low_power_pin,
  input wire interrupt_n_pin_oe,
  input wire [15:0] module_temp,
  input wire [15:0] nv_plug_count,
  input wire nv_power_wr,
  input wire [7:0] nv_power_data,
  input wire nv_count_wr,
  input wire [15:0] nv_count_data,
  input wire pwm_heater_out,
  input wire spot_a_out,
  input wire spot_b_out,
  input wire low_power_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Slack of three cycles for registered heater paths
  lp_off_a: assert property (
    low_power_mode [*4] |-> !(pwm_heater_out || spot_a_out || spot_b_out))
    else $error("heater on in low power");
  hot_off_a: assert property (
    (!module_temp[15] && module_temp >= 16'h4600) [*4] |-> !pwm_heater_out)
    else $error("pwm on above cut-off");
  nv_store_a: assert property (
    reg_wr && module_reset_n_pin && reg_addr == 8'h62 |=>
    nv_power_wr && nv_power_data == $past(reg_wdata))
    else $error("power byte not stored");
  rst_read_a: assert property (
    reg_rd && !module_reset_n_pin |=> reg_rdata == 8'hFF)
    else $error("read in reset not FF");
  lp_read_a: assert property (
    reg_rd && module_reset_n_pin && reg_page == 8'h02 &&
    reg_addr == 8'h92 |=> reg_rdata == {7'h00, $past(low_power_pin)})
    else $error("low power pin readback");
  int_drive_a: assert property (
    reg_wr && module_reset_n_pin && reg_page == 8'h02 &&
    reg_addr == 8'h93 |=> ##1
    interrupt_n_pin_oe == !$past(reg_wdata[0], 2))
    else $error("interrupt pin drive");
  cnt_incr_a: assert property (
    nv_count_wr |-> nv_count_data == nv_plug_count + 16'h0001)
    else $error("count not plus one");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  cover property (nv_count_wr);
  cover property (reg_wr && reg_addr == 8'h62);
  cover property (module_temp >= 16'h4600 && !pwm_heater_out);
endmodule // pdc_asserts
bind pdc_top pdc_asserts chk (.*);

// [pdc_host.sv]
`timescale 1ns/1ps
module pdc_host (
  input wire clk_sys,
  input wire [7:0] reg_rdata,
  output reg [7:0] reg_page,
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_wdata
);
  initial
  begin
    reg_page = 8'h00;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released address and data lines show the inverse so stale values never match
  task xfer(input w, input [7:0] p, input [7:0] a, input [7:0] d,
    output [7:0] q);
  begin
    @(negedge clk_sys);
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  end
  endtask
endmodule // pdc_host

// [tb.sv]
`timescale 1ns/1ps
module tb;
  reg clk_sys;
  reg rst_n;
  wire [7:0] reg_page;
  wire [7:0] reg_addr;
  wire reg_wr;
  wire reg_rd;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  reg module_reset_n_pin;
  reg low_power_pin;
  wire interrupt_n_pin_o;
  wire interrupt_n_pin_oe;
  reg [15:0] module_temp;
  reg [7:0] nv_power_value;
  reg [15:0] nv_plug_count;
  wire nv_power_wr;
  wire [7:0] nv_power_data;
  wire nv_count_wr;
  wire [15:0] nv_count_data;
  wire pwm_heater_out;
  wire spot_a_out;
  wire spot_b_out;
  wire low_power_mode;
  integer err_total;
  integer checks;
  integer n;
  integer i;
  reg [7:0] q;
  localparam [7:0] pg2 = 8'h02;
  pdc_top dut (.*);
  pdc_host host (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Nonvolatile store behind the block
  always @(posedge clk_sys)
  begin
    if (nv_power_wr)
      nv_power_value <= nv_power_data;
    if (nv_count_wr)
      nv_plug_count <= nv_count_data;
  end
  task w(input integer k);
    repeat (k) @(negedge clk_sys);
  endtask
  task chk(input [15:0] g, input [15:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task wr(input [7:0] p, input [7:0] a, input [7:0] d);
  begin
    host.xfer(1'b1, p, a, d, q);
    w(8);
  end
  endtask
  task rc(input [7:0] p, input [7:0] a, input [7:0] e);
  begin
    host.xfer(1'b0, p, a, 8'h00, q);
    chk(q, e);
  end
  endtask
  // Any 63-cycle span holds exactly duty high cycles
  task hc(input [15:0] e);
  begin
    n = 0;
    repeat (63)
    begin
      @(negedge clk_sys);
      if (pwm_heater_out === 1'b1)
        n = n + 1;
    end
    chk(n[15:0], e);
  end
  endtask
  task t_regs;
  begin
    rc(8'h00, 8'h62, 8'h81);
    chk({pwm_heater_out, spot_a_out, spot_b_out}, 3'b000);
    rc(pg2, 8'h8F, 8'h00);
    rc(pg2, 8'h90, 8'h00);
    rc(pg2, 8'h8D, 8'h00);
    rc(pg2, 8'h8E, 8'h13);
    wr(pg2, 8'h8D, 8'h55);
    rc(pg2, 8'h8D, 8'h00);
    rc(pg2, 8'hA0, 8'h00);
    rc(pg2, 8'h91, 8'h01);
  end
  endtask
  task t_mode;
  begin
    chk(low_power_mode, 1'b1);
    rc(pg2, 8'h92, 8'h01);
    wr(8'h00, 8'h5D, 8'h01);
    chk(low_power_mode, 1'b0);
    rc(8'h00, 8'h5D, 8'h01);
    wr(8'h00, 8'h5D, 8'h03);
    chk(low_power_mode, 1'b1);
    wr(8'h00, 8'h5D, 8'h00);
    low_power_pin = 1'b0;
    w(4);
    chk(low_power_mode, 1'b0);
    rc(pg2, 8'h92, 8'h00);
    wr(pg2, 8'h93, 8'h00);
    chk({interrupt_n_pin_oe, interrupt_n_pin_o}, 2'b10);
    wr(pg2, 8'h93, 8'h01);
    chk(interrupt_n_pin_oe, 1'b0);
  end
  endtask
  task t_heat;
  begin
    chk({spot_a_out, spot_b_out}, 2'b01);
    wr(8'h00, 8'h62, 8'hC0);
    chk({spot_a_out, spot_b_out}, 2'b11);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(8'h00, 8'h62, i[7:0] * 8'h1F);
      chk({spot_a_out, spot_b_out}, 2'b00);
      hc(i[15:0] * 16'h001F);
    end
    low_power_pin = 1'b1;
    w(4);
    hc(16'h0000);
    low_power_pin = 1'b0;
    w(4);
  end
  endtask
  task t_hot;
  begin
    module_temp = 16'h45FF;
    hc(16'h003E);
    module_temp = 16'h4600;
    w(4);
    hc(16'h0000);
    module_temp = 16'h4101;
    hc(16'h0000);
    module_temp = 16'h4100;
    w(4);
    hc(16'h003E);
    module_temp = 16'h1900;
  end
  endtask
  task t_stage;
  begin
    wr(pg2, 8'h90, 8'h01);
    rc(pg2, 8'h90, 8'h01);
    wr(8'h00, 8'h62, 8'hC0);
    chk({spot_a_out, spot_b_out}, 2'b11);
    module_reset_n_pin = 1'b0;
    w(2);
    rc(8'h00, 8'h62, 8'hFF);
    module_reset_n_pin = 1'b1;
    n = 0;
    while (spot_a_out !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk(n > 870 && n < 890, 1'b1);
    chk(spot_b_out, 1'b0);
    w(1100);
    chk(spot_b_out, 1'b1);
    rc(pg2, 8'h8D, 8'h01);
    wr(pg2, 8'h8F, 8'h00);
    wr(pg2, 8'h90, 8'h00);
    module_reset_n_pin = 1'b0;
    w(2);
    module_reset_n_pin = 1'b1;
    w(6);
    chk({spot_a_out, spot_b_out}, 2'b11);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    module_reset_n_pin = 1'b1;
    low_power_pin = 1'b1;
    module_temp = 16'h1900;
    nv_power_value = 8'h81;
    nv_plug_count = 16'h12FF;
    w(5);
    rst_n = 1'b1;
    w(3);
    t_regs;
    t_mode;
    t_heat;
    t_hot;
    t_stage;
    conclude;
  end
  // Run needs about 2700 cycles
  initial
  begin
    #200000;
    err_total = err_total + 1;
    conclude;
  end
endmodule // tb
